// File: msb_defines.svh
// timing and protocol constants for the single-wire bus slave front end
// assumes a 125 MHz system clock; included by bare name
// What the bus protocol requires
// R1: master alone sets bit timing, bus rate 10 to 100 kHz.
// R2: stay locked with input edges off by up to 0.06 unit interval.
// R3: keep decoding while rate drifts up to 0.50 percent per byte.
// R4: tolerate 5 percent total rate drift within one command.
// R5: slave-driven edges within 0.25 unit interval of ideal position.
// R6: line high 600 us is standby pulse; slave resets and enters standby.
// R7: in standby, the falling edge of header low pulse wakes slave.
// R8: after end ack plus slave ack, master waits 10 us, then header.
// R9: any other command end needs a standby pulse before next command.
// R10: after power-on master makes low-to-high transition before any traffic.
// R11: master sends no standby pulse while the slave drives the line.
// R12: master on error sends standby pulse and repeats whole command.
// R13: header is line low at least 5 us, then pattern 01010101.
// R14: slave measures bit period from header and uses it thereafter.
// R15: all bytes travel most significant bit first.
// R16: every bit is Manchester coded on the one shared line.
// R17: write cycle ends within 5 ms, or 10 ms for whole-array commands.
// R18: received command held in an eight-bit instruction register.
// R19: line input rejects glitches up to 50 ns.
// R20: master starts all traffic; slave drives only its assigned slots.
// R21: each byte is followed by master ack bit then slave ack bit.
// R22: slave ack is a 1; negative ack has no middle edge.
// R23: after header master sends continue ack, slave answers negative ack.
// R24: slave re-measures timing on every master continue ack middle edge.
// R25: a 1 rises at mid-bit, a 0 falls at mid-bit.
// R26: slave leaves the line undriven whenever it is not transmitting.
`ifndef MSB_DEFINES_SVH
`define MSB_DEFINES_SVH
`define MSB_CLK_MHZ      125
`define MSB_STBY_US      600
`define MSB_HDR_LOW_NS   5000
`define MSB_GLITCH_NS    50
`define MSB_TE_MAX_US    100
`define MSB_WC_SHORT_US  5000
`define MSB_WC_LONG_US   10000
`define MSB_HDR_TAIL     3'h5
`define MSB_HDR_MEAS_N   3'h4
`define MSB_SLOT_MAK     4'h8
`define MSB_SLOT_SACK    4'h9
`define MSB_SLOT_LAST    4'h7
`define MSB_HDR_FIRST    4'h5
`endif

// File: msb_master_model.sv
// bus master model driving the shared Manchester line
// assumes the bench resolves the wire with a pull-up when nobody drives
`timescale 1ns/1ps
module msb_master_model #(
  parameter int P       = 1250,
  parameter int HDR_LOW = 700
) (
  input wire logic clk_sys,
  input wire logic line,
  output logic     m_oe,
  output logic     m_out
);
  localparam logic [7:0] HDR_PAT = 8'h55;
  initial
  begin
    m_oe  = 1'b0;
    m_out = 1'b1;
  end
  task automatic drive(input logic v, input int n);
    @(posedge clk_sys);
    m_oe  <= 1'b1;
    m_out <= v;
    repeat (n - 1) @(posedge clk_sys);
  endtask
  task automatic mbit(input logic b);
    drive(~b, P / 2);
    drive(b, P - P / 2);
  endtask
  // line released for the slave slot, sampled mid-half at falling edges
  task automatic slot(output logic lo, output logic hi);
    @(posedge clk_sys);
    m_oe <= 1'b0;
    repeat (P / 4) @(posedge clk_sys);
    @(negedge clk_sys);
    lo = line;
    repeat (P / 2) @(posedge clk_sys);
    @(negedge clk_sys);
    hi = line;
    repeat (P / 4) @(posedge clk_sys);
  endtask
  task automatic header(output logic lo, output logic hi);
    drive(1'b0, HDR_LOW);
    for (int i = 7; i >= 0; i--)
      mbit(HDR_PAT[i]);
    mbit(1'b1);
    slot(lo, hi);
  endtask
  task automatic send_byte(input logic [7:0] b, input logic master_continue_ack,
                           output logic lo, output logic hi);
    for (int i = 7; i >= 0; i--)
      mbit(b[i]);
    mbit(master_continue_ack);
    slot(lo, hi);
  endtask
endmodule

// File: msb_pkg.sv
// types shared by the single-wire bus slave front end
// assumes msb_defines.svh for numeric constants
package msb_pkg;
  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } msb_rx_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STANDBY,
    ST_HDR_LOW,
    ST_HDR_MEAS,
    ST_BITS
  } msb_state_t;
endpackage

// File: msb_slave.sv
// single-wire Manchester bus slave front end with receive fifo
// assumes one clk_sys domain at 125 MHz; line pin split into in/out/oe
`timescale 1ns/1ps
`include "msb_defines.svh"

// ----------------------------------------
// receive fifo
// ----------------------------------------
module msb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2) begin : g_bad_depth
    $error("fifo depth must be at least 2");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             do_wr;
  logic             do_rd;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_idx];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;

  always_ff @(posedge clk_sys)
    if (do_wr)
      mem[wr_idx] <= in_data;

  always_ff @(posedge clk_sys)
    if (rst)
    begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end
    else
    begin
      if (do_wr)
        wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + AW'(1);
      if (do_rd)
        rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + AW'(1);
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
endmodule

// ----------------------------------------
// bus slave top
// ----------------------------------------
module msb_slave #(
  parameter int STBY_CYC     = `MSB_STBY_US * `MSB_CLK_MHZ,
  parameter int WC_SHORT_CYC = `MSB_WC_SHORT_US * `MSB_CLK_MHZ,
  parameter int WC_LONG_CYC  = `MSB_WC_LONG_US * `MSB_CLK_MHZ,
  parameter int FIFO_DEPTH   = 8
) (
  input  wire logic            clk_sys,
  input  wire logic            rst,
  input  wire logic            line_in,
  output logic                 line_out,
  output logic                 line_oe,
  output logic                 rx_valid,
  input  wire logic            rx_ready,
  output msb_pkg::msb_rx_t     rx_data,
  input  wire logic            tx_valid,
  input  wire logic [7:0]      tx_data,
  output logic                 tx_ready,
  input  wire logic            nack_req,
  output logic [7:0]           instr,
  output logic                 cmd_done,
  output logic                 in_standby,
  output logic                 in_idle,
  input  wire logic            wc_start,
  input  wire logic            wc_long,
  output logic                 wc_busy
);
  localparam int HDR_LOW_CYC = (`MSB_HDR_LOW_NS * `MSB_CLK_MHZ + 999) / 1000;
  localparam int GLITCH_CYC  = (`MSB_GLITCH_NS * `MSB_CLK_MHZ + 999) / 1000;
  localparam int HDR_MAX_CYC = 5 * `MSB_TE_MAX_US * `MSB_CLK_MHZ;
  localparam int TW          = 17;
  localparam int SW          = $clog2(STBY_CYC + 1);
  localparam int WW          = $clog2(WC_LONG_CYC + 1);
  if (STBY_CYC < 2 || WC_SHORT_CYC < 1 || WC_LONG_CYC < WC_SHORT_CYC) begin : g_bad_par
    $error("timing parameters out of range");
  end

  // ----------------------------------------
  // input synchroniser and spike filter
  // ----------------------------------------
  logic       sync1;
  logic       sync2;
  logic       sync3;
  logic       line_f;
  logic [3:0] flt_cnt;
  logic       rise;
  logic       fall;
  logic       edge_any;

  always_ff @(posedge clk_sys)
    if (rst)
    begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
    end
    else
    begin
      sync1 <= line_in;
      sync2 <= sync1;
      sync3 <= sync2;
    end

  // level must hold past the spike width before it counts
  always_ff @(posedge clk_sys)
    if (rst)
    begin
      line_f  <= 1'b1;
      flt_cnt <= '0;
      rise    <= 1'b0;
      fall    <= 1'b0;
    end
    else
    begin
      rise <= 1'b0;
      fall <= 1'b0;
      if (sync2 != sync3 || sync3 == line_f)
        flt_cnt <= '0;
      else if (flt_cnt == 4'(GLITCH_CYC - 1))                           // R19
      begin
        flt_cnt <= '0;
        line_f  <= sync3;
        rise    <= sync3;
        fall    <= ~sync3;
      end
      else
        flt_cnt <= flt_cnt + 4'h1;
    end
  assign edge_any = rise | fall;

  // ----------------------------------------
  // standby pulse detector
  // ----------------------------------------
  logic [SW-1:0] hi_cnt;
  logic          stby_hit;

  always_ff @(posedge clk_sys)
    if (rst || !line_f || line_oe)                                       // R11
      hi_cnt <= '0;
    else if (hi_cnt != SW'(STBY_CYC))
      hi_cnt <= hi_cnt + SW'(1);
  assign stby_hit = (hi_cnt == SW'(STBY_CYC - 1));                       // R6

  // ----------------------------------------
  // bit engine
  // ----------------------------------------
  msb_pkg::msb_state_t state;
  logic [TW-1:0] t;
  logic [TW-1:0] period;
  logic [3:0]    slot;
  logic [2:0]    ecnt;
  logic [7:0]    sh;
  logic [7:0]    tx_sh;
  logic          tx_mode;
  logic          is_hdr;
  logic          master_continue_ack;
  logic          slave_ack;
  logic          push_ok;
  logic [1:0]    byte_idx;
  logic          push_valid;
  msb_pkg::msb_rx_t push_data;
  logic          push_ready;
  logic          owns;
  logic          drv;
  logic          bitv;
  logic [TW-1:0] half;
  logic [TW-1:0] win_lo;
  logic [TW-1:0] win_hi;

  assign owns   = (slot == `MSB_SLOT_SACK) || (tx_mode && slot <= `MSB_SLOT_LAST); // R20
  assign half   = period >> 1;
  // quarter-period window absorbs jitter and per-byte drift
  assign win_lo = period - (period >> 2);                                // R2
  assign win_hi = period + (period >> 2);                                // R3
  // header never acked; full fifo or upper refusal gives negative ack
  assign drv    = (slot == `MSB_SLOT_SACK)
                ? (!is_hdr && !nack_req && (tx_mode || push_ok)) : 1'b1;  // R22 R23
  assign bitv   = (slot == `MSB_SLOT_SACK) ? 1'b1 : tx_sh[7];              // R15

  always_ff @(posedge clk_sys)
    if (rst)
      push_ok <= 1'b0;
    else if (push_valid)
      push_ok <= push_ready;

  always_ff @(posedge clk_sys)
    if (rst)
    begin
      state      <= msb_pkg::ST_IDLE;                                    // R10
      t          <= '0;
      period     <= '0;
      slot       <= '0;
      ecnt       <= '0;
      sh         <= '0;
      tx_sh      <= '0;
      tx_mode    <= 1'b0;
      is_hdr     <= 1'b0;
      master_continue_ack        <= 1'b0;
      slave_ack        <= 1'b0;
      byte_idx   <= '0;
      push_valid <= 1'b0;
      push_data  <= '0;
      instr      <= '0;
      line_out   <= 1'b1;
      line_oe    <= 1'b0;
      tx_ready   <= 1'b0;
      cmd_done   <= 1'b0;
    end
    else if (stby_hit)
    begin
      state    <= msb_pkg::ST_STANDBY;                                   // R6
      line_oe  <= 1'b0;
      line_out <= 1'b1;
      tx_mode <= 1'b0;
    end
    else
    begin
      push_valid <= 1'b0;
      tx_ready   <= 1'b0;
      cmd_done   <= 1'b0;
      t          <= t + TW'(1);
      unique case (state)
        msb_pkg::ST_IDLE:
        begin
          line_oe  <= 1'b0;                                              // R26
          line_out <= 1'b1;
        end
        msb_pkg::ST_STANDBY:
          if (fall)                                                      // R7
          begin
            state <= msb_pkg::ST_HDR_LOW;
            t     <= '0;
          end
        msb_pkg::ST_HDR_LOW:
          if (rise)
          begin
            state <= (t >= TW'(HDR_LOW_CYC)) ? msb_pkg::ST_HDR_MEAS : msb_pkg::ST_IDLE; // R13
            ecnt  <= '0;
          end
        msb_pkg::ST_HDR_MEAS:
          if (edge_any)
          begin
            ecnt <= ecnt + 3'h1;
            if (ecnt == '0)
              t <= '0;
            if (ecnt == `MSB_HDR_MEAS_N)
            begin
              period  <= t >> 2;                                         // R14 R4
              t       <= '0;
              state   <= msb_pkg::ST_BITS;
              slot    <= `MSB_HDR_FIRST;
              is_hdr  <= 1'b1;
              tx_mode <= 1'b0;
              byte_idx <= '0;
            end
          end
          else if (t > TW'(HDR_MAX_CYC))
            state <= msb_pkg::ST_IDLE;
        msb_pkg::ST_BITS:
          if (!owns)
          begin
            if (t == half)
            begin
              line_oe  <= 1'b0;                                          // R26
              line_out <= 1'b1;
            end
            if (edge_any && t >= win_lo)
            begin
              t <= '0;
              if (slot == `MSB_SLOT_MAK)
              begin
                period <= t;                                             // R24
                master_continue_ack    <= rise;                                          // R21
                slot   <= `MSB_SLOT_SACK;
                if (is_hdr && !rise)
                  state <= msb_pkg::ST_IDLE;                             // R23
              end
              else
              begin
                sh   <= {sh[6:0], rise};                                 // R25 R15
                slot <= slot + 4'h1;
                if (slot == `MSB_SLOT_LAST && is_hdr && {sh[1:0], rise} != `MSB_HDR_TAIL)
                  state <= msb_pkg::ST_IDLE;
                if (slot == `MSB_SLOT_LAST && !is_hdr)
                begin
                  push_valid      <= 1'b1;
                  push_data.data  <= {sh[6:0], rise};
                  push_data.first <= (byte_idx == 2'h0);
                  if (byte_idx == 2'h1)
                    instr <= {sh[6:0], rise};                            // R18
                end
              end
            end
            else if (t > win_hi)
              state <= msb_pkg::ST_IDLE;                                 // missed edge
          end
          else
          begin
            if (t == half)
            begin
              line_oe  <= drv;                                           // R20
              // released output rests high so the pin never floats low
              line_out <= drv ? ~bitv : 1'b1;                            // R16
              if (slot == `MSB_SLOT_SACK)
                slave_ack <= drv;
            end
            if (t == period)
            begin
              t        <= '0;                                            // R5
              line_out <= bitv;                                          // R25
              if (slot != `MSB_SLOT_SACK)
              begin
                tx_sh <= {tx_sh[6:0], 1'b0};
                slot  <= slot + 4'h1;
              end
              else if (is_hdr)
              begin
                is_hdr <= 1'b0;
                slot   <= '0;
              end
              else if (!slave_ack)
                state <= msb_pkg::ST_IDLE;                               // R9
              else if (!master_continue_ack)
              begin
                state    <= msb_pkg::ST_STANDBY;                         // R8
                line_oe  <= 1'b0;                                        // R26
                cmd_done <= 1'b1;
              end
              else
              begin
                slot     <= '0;
                byte_idx <= (byte_idx == 2'h2) ? byte_idx : byte_idx + 2'h1;
                tx_mode  <= tx_valid;
                tx_sh    <= tx_data;
                tx_ready <= tx_valid;
              end
            end
          end
        default:
          state <= msb_pkg::ST_IDLE;
      endcase
    end

  assign in_standby = (state == msb_pkg::ST_STANDBY);
  assign in_idle    = (state == msb_pkg::ST_IDLE);

  // ----------------------------------------
  // receive buffer
  // ----------------------------------------
  msb_fifo #(
    .WIDTH ($bits(msb_pkg::msb_rx_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_data)
  );

  // ----------------------------------------
  // self-timed write cycle
  // ----------------------------------------
  logic [WW-1:0] wc_cnt;

  always_ff @(posedge clk_sys)
    if (rst)
      wc_cnt <= '0;
    else if (wc_start && wc_cnt == '0)
      wc_cnt <= wc_long ? WW'(WC_LONG_CYC) : WW'(WC_SHORT_CYC);          // R17
    else if (wc_cnt != '0)
      wc_cnt <= wc_cnt - WW'(1);
  assign wc_busy = (wc_cnt != '0);
endmodule

// File: msb_slave_sva.sv
// port checker for the single-wire bus slave front end
// assumes binding onto msb_slave; one clock domain, sync active-high reset
`timescale 1ns/1ps
module msb_slave_sva #(
  parameter int STBY_CYC    = 75000,
  parameter int WC_LONG_CYC = 1250000
) (
  input wire logic             clk_sys,
  input wire logic             rst,
  input wire logic             line_in,
  input wire logic             line_out,
  input wire logic             line_oe,
  input wire logic             cmd_done,
  input wire logic             in_standby,
  input wire logic             in_idle,
  input wire logic             wc_start,
  input wire logic             wc_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  int hi_cnt;
  int busy_cnt;
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  // margin covers the input filter delay
  always_ff @(posedge clk_sys)
  begin
    if (rst || !line_in || line_oe)
      hi_cnt <= 0;
    else if (hi_cnt < STBY_CYC + 64)
      hi_cnt <= hi_cnt + 1;
  end
  always_ff @(posedge clk_sys)
  begin
    if (rst || !wc_busy)
      busy_cnt <= 0;
    else
      busy_cnt <= busy_cnt + 1;
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_ack_low;
    line_oe && !line_out;
  endsequence
  sequence s_glitch;
    in_standby && $fell(line_in) ##1 (!line_in)[*4] ##1 line_in;
  endsequence
  sequence s_hdr_low;
    in_standby && $fell(line_in) ##1 (!line_in)[*8];
  endsequence
  AST_OE_STBY: assert property (in_standby |-> !line_oe)
    else $error("slave drives line in standby");
  AST_OUT_IDLE: assert property (!line_oe |-> line_out)
    else $error("released line output not high");
  AST_ACK_SHAPE: assert property ($rose(line_oe) |-> s_ack_low[*8])
    else $error("slave ack first half not low");
  AST_DONE_PULSE: assert property (cmd_done |=> !cmd_done)
    else $error("command done longer than one cycle");
  AST_DONE_STBY: assert property (cmd_done |-> ##[0:1] in_standby)
    else $error("good command end not in standby");
  AST_MODE_EXCL: assert property (!(in_standby && in_idle))
    else $error("standby and idle together");
  AST_STBY_ENTRY: assert property (hi_cnt == STBY_CYC + 24 |-> in_standby)
    else $error("standby pulse not taken");
  AST_WAKE: assert property (s_hdr_low |-> ##[0:12] !in_standby)
    else $error("header low did not wake slave");
  AST_GLITCH: assert property (s_glitch |=> in_standby[*8])
    else $error("short spike left standby");
  AST_WC_START: assert property (wc_start && !wc_busy |=> wc_busy)
    else $error("write timer did not start");
  AST_WC_MAX: assert property (busy_cnt <= WC_LONG_CYC)
    else $error("write timer too long");
endmodule

// File: tb_top.sv
// self-checking bench for the single-wire bus slave front end
// assumes msb_master_model as bus master; slave transmit path left quiet
`timescale 1ns/1ps
module tb_top;
  localparam int P    = 1250;
  localparam int STBY = 2000;
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  logic             line_in, line_out, line_oe, m_oe, m_out;
  logic             rx_valid, tx_ready, cmd_done, in_standby, in_idle, wc_busy;
  logic             rx_ready = 1'b0, nack_req = 1'b0, wc_start = 1'b0, wc_long = 1'b0;
  logic [7:0]       instr;
  msb_pkg::msb_rx_t rx_data;
  int               err_total = 0, n_compared = 0, n_done = 0;
  always #4 clk_sys = ~clk_sys;
  // pull-up holds the wire high when nobody drives
  assign line_in = line_oe ? line_out : (m_oe ? m_out : 1'b1);
  always @(posedge clk_sys)
    if (cmd_done === 1'b1)
      n_done <= n_done + 1;
  msb_slave #(.STBY_CYC(STBY), .WC_SHORT_CYC(50), .WC_LONG_CYC(100)) i_msb_slave (
    .clk_sys(clk_sys), .rst(rst), .line_in(line_in), .line_out(line_out),
    .line_oe(line_oe), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .tx_valid(1'b0), .tx_data(8'h00), .tx_ready(tx_ready), .nack_req(nack_req),
    .instr(instr), .cmd_done(cmd_done), .in_standby(in_standby), .in_idle(in_idle),
    .wc_start(wc_start), .wc_long(wc_long), .wc_busy(wc_busy));
  msb_master_model #(.P(P), .HDR_LOW(700)) i_msb_master_model (
    .clk_sys(clk_sys), .line(line_in), .m_oe(m_oe), .m_out(m_out));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    @(negedge clk_sys);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pop(input logic [8:0] exp);
    chk("rx_valid", 9'h1, 9'(rx_valid));
    chk("rx_data", exp, rx_data);
    @(posedge clk_sys);
    rx_ready <= 1'b1;
    @(posedge clk_sys);
    rx_ready <= 1'b0;
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("line_oe", 9'h0, 9'(line_oe));
    chk("in_idle", 9'h1, 9'(in_idle));
    chk("rx_valid", 9'h0, 9'(rx_valid));
    chk("wc_busy", 9'h0, 9'(wc_busy));
    chk("tx_ready", 9'h0, 9'(tx_ready));
  endtask
  task automatic t_standby;
    i_msb_master_model.drive(1'b0, 10);
    i_msb_master_model.drive(1'b1, STBY + 40);
    chk("in_standby", 9'h1, 9'(in_standby));
    chk("in_idle", 9'h0, 9'(in_idle));
    i_msb_master_model.drive(1'b0, 5);
    i_msb_master_model.drive(1'b1, 40);
    chk("spike standby", 9'h1, 9'(in_standby));
  endtask
  task automatic t_cmd;
    logic lo, hi;
    int   n0;
    n0 = n_done;
    i_msb_master_model.header(lo, hi);
    chk("header ack", 9'h3, 9'({lo, hi}));
    i_msb_master_model.send_byte(8'ha5, 1'b1, lo, hi);
    chk("address ack", 9'h1, 9'({lo, hi}));
    i_msb_master_model.send_byte(8'h3c, 1'b0, lo, hi);
    chk("end ack", 9'h1, 9'({lo, hi}));
    for (int i = 0; i < 100 && in_standby !== 1'b1; i++)
      @(posedge clk_sys);
    chk("standby", 9'h1, 9'(in_standby));
    chk("cmd_done", 9'h1, 9'(n_done - n0));
    chk("instr", 9'h03c, 9'(instr));
    pop(9'h1a5);
    pop(9'h03c);
  endtask
  // second command without standby pulse, refused by negative ack
  task automatic t_nack;
    logic lo, hi;
    i_msb_master_model.drive(1'b1, 1260);
    i_msb_master_model.header(lo, hi);
    chk("header ack", 9'h3, 9'({lo, hi}));
    nack_req <= 1'b1;
    i_msb_master_model.send_byte(8'h5a, 1'b1, lo, hi);
    chk("negative ack", 9'h3, 9'({lo, hi}));
    for (int i = 0; i < 100 && in_idle !== 1'b1; i++)
      @(posedge clk_sys);
    chk("in_idle", 9'h1, 9'(in_idle));
    nack_req <= 1'b0;
    i_msb_master_model.drive(1'b1, STBY + 40);
    chk("recovery standby", 9'h1, 9'(in_standby));
  endtask
  task automatic t_wc;
    int n;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      @(posedge clk_sys);
      wc_start <= 1'b1;
      wc_long  <= k[0];
      for (int i = 0; i < 200; i++)
      begin
        @(posedge clk_sys);
        if (i == 2)
          wc_start <= 1'b0;
        @(negedge clk_sys);
        n += (wc_busy === 1'b1);
      end
      chk("wc cycles", 9'(k ? 100 : 50), 9'(n));
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_standby();
    t_cmd();
    t_nack();
    t_wc();
    stop_test();
  end
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    err_total++;
    stop_test();
  end
endmodule
bind msb_slave msb_slave_sva #(.STBY_CYC(STBY_CYC), .WC_LONG_CYC(WC_LONG_CYC)) i_msb_slave_sva (
  .clk_sys(clk_sys), .rst(rst), .line_in(line_in), .line_out(line_out),
  .line_oe(line_oe), .cmd_done(cmd_done), .in_standby(in_standby), .in_idle(in_idle),
  .wc_start(wc_start), .wc_busy(wc_busy));
